/* design/rpf_pkg.sv */
// rpf_pkg: shared constants for the packet address filter.
// assumes a single 10 MHz system clock and header fields from the radio framer.
package rpf_pkg;

  // field widths
  localparam int unsigned RPF_CH_W = 7;
  localparam int unsigned RPF_TAG_W = 16;
  localparam int unsigned RPF_ADDR_W = 16;
  localparam int unsigned RPF_DATA_W = 8;
  localparam int unsigned RPF_CNT_W = 16;

  // destination value that always means every module in range
  localparam logic [15:0] RPF_GLOBAL_ADDR = 16'hFFFF;

  // reset values of status
  localparam logic [2:0] RPF_REASON_NONE = 3'h0;
  localparam logic [15:0] RPF_CNT_RESET = 16'h0000;

  // drop reason bit positions
  localparam int unsigned RPF_REASON_HOP = 0;
  localparam int unsigned RPF_REASON_TAG = 1;
  localparam int unsigned RPF_REASON_ADDR = 2;

  // timing
  localparam longint unsigned RPF_CLK_HZ = 10000000;
  localparam longint unsigned RPF_SYNC_TIME_MS = 35;
  localparam longint unsigned RPF_COLD_START_MS = 50;
  // longest times: round down, never below one cycle
  localparam int unsigned RPF_SYNC_CYCLES =
    int'((RPF_SYNC_TIME_MS * RPF_CLK_HZ) / 1000 > 0 ?
         (RPF_SYNC_TIME_MS * RPF_CLK_HZ) / 1000 : 1);
  localparam int unsigned RPF_COLD_START_CYCLES =
    int'((RPF_COLD_START_MS * RPF_CLK_HZ) / 1000 > 0 ?
         (RPF_COLD_START_MS * RPF_CLK_HZ) / 1000 : 1);
  localparam int unsigned RPF_TIMER_W = 20;

  // receive path states
  typedef enum logic [1:0] {
    RPF_IDLE,
    RPF_FORWARD,
    RPF_DISCARD
  } rpf_rx_state_e;

endpackage

/* design/rpf_tx_classifier.sv */
// rpf_tx_classifier: marks an outgoing packet global or local.
// assumes txStart is a one-cycle pulse on clk_sys.
`timescale 1ns/1ps
module rpf_tx_classifier import rpf_pkg::*; #(
  parameter int unsigned ADDR_W = RPF_ADDR_W
) (
  input wire logic clk_sys, // system clock
  input wire logic reset, // sync reset, active high
  input wire logic clkEn, // freezes state when low
  input wire logic txStart, // new outgoing packet
  input wire logic [ADDR_W-1:0] transmitterDestination, // packet destination
  input wire logic [ADDR_W-1:0] addressMask, // own mask
  output logic txIsGlobal, // packet goes to many modules
  output logic txIsLocal, // packet goes to one module
  output logic txClassValid // classification strobe
);

  logic globalNext;

  // all-ones destination always global, else masked compare
  always_comb begin
    globalNext = (transmitterDestination == ADDR_W'(RPF_GLOBAL_ADDR)) ||
                 ((transmitterDestination & addressMask) == addressMask);
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      txIsGlobal <= 1'b0;
      txIsLocal <= 1'b0;
      txClassValid <= 1'b0;
    end else if (clkEn) begin
      txClassValid <= txStart;
      if (txStart) begin
        txIsGlobal <= globalNext;
        txIsLocal <= !globalNext;
      end
    end
  end

endmodule // rpf_tx_classifier

/* design/rpf_sync_timer.sv */
// rpf_sync_timer: peer-to-peer sync and cold-start timing.
// assumes rxInitializer pulses when a peer's hop initializer is heard.
`timescale 1ns/1ps
module rpf_sync_timer import rpf_pkg::*; #(
  parameter int unsigned SYNC_CYCLES = RPF_SYNC_CYCLES,
  parameter int unsigned COLD_START_CYCLES = RPF_COLD_START_CYCLES,
  parameter int unsigned TIMER_W = RPF_TIMER_W
) (
  input wire logic clk_sys, // system clock
  input wire logic reset, // sync reset, active high
  input wire logic clkEn, // freezes state when low
  input wire logic rxInitializer, // peer hop pattern heard
  output logic syncLocked, // hop pattern held
  output logic masterRole, // own timing drives the pattern
  output logic txReady // transmit permitted
);

  logic [TIMER_W-1:0] elapsed_reg;

  // counts from cold start, stops once txReady and syncLocked are both set
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      elapsed_reg <= '0;
    end else if (clkEn && !(txReady && syncLocked)) begin
      elapsed_reg <= elapsed_reg + TIMER_W'(1);
    end
  end

  // follow a peer if heard, else lead after the sync window
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      syncLocked <= 1'b0;
      masterRole <= 1'b0;
    end else if (clkEn && !syncLocked) begin
      if (rxInitializer) begin
        syncLocked <= 1'b1;
        masterRole <= 1'b0;
      end else if (elapsed_reg >= TIMER_W'(SYNC_CYCLES - 1)) begin
        syncLocked <= 1'b1;
        masterRole <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      txReady <= 1'b0;
    end else if (clkEn && elapsed_reg >= TIMER_W'(COLD_START_CYCLES - 1)) begin
      txReady <= 1'b1;
    end
  end

endmodule // rpf_sync_timer

/* design/rpf_address_filter.sv */
// rpf_address_filter: receive filtering and transmit address classification.
// assumes header and payload strobes come from framer logic on clk_sys.
`timescale 1ns/1ps
module rpf_address_filter import rpf_pkg::*; #(
  parameter int unsigned CH_W = RPF_CH_W,
  parameter int unsigned TAG_W = RPF_TAG_W,
  parameter int unsigned ADDR_W = RPF_ADDR_W,
  parameter int unsigned DATA_W = RPF_DATA_W,
  parameter int unsigned CNT_W = RPF_CNT_W,
  parameter int unsigned SYNC_CYCLES = RPF_SYNC_CYCLES,
  parameter int unsigned COLD_START_CYCLES = RPF_COLD_START_CYCLES
) (
  input wire logic clk_sys, // system clock, 10 MHz
  input wire logic reset, // sync reset, active high
  input wire logic clkEn, // freezes all state when low
  // configuration
  input wire logic [CH_W-1:0] hoppingChannel, // own hop channel
  input wire logic [TAG_W-1:0] vendorNetworkTag, // own network tag
  input wire logic [ADDR_W-1:0] sourceAddress, // own address
  input wire logic [ADDR_W-1:0] addressMask, // own mask
  input wire logic [ADDR_W-1:0] transmitterDestination, // outgoing destination
  // transmit classification
  input wire logic txStart, // new outgoing packet
  output logic txIsGlobal, // outgoing packet is global
  output logic txIsLocal, // outgoing packet is local
  output logic txClassValid, // classification strobe
  // received header
  input wire logic rxHdrValid, // header strobe
  input wire logic [CH_W-1:0] rxHoppingChannel, // header channel
  input wire logic [TAG_W-1:0] rxVendorNetworkTag, // header tag
  input wire logic [ADDR_W-1:0] rxDestinationAddress, // header destination
  input wire logic rxAckRequested, // sender wants acknowledge
  input wire logic rxInitializer, // header carries hop initializer
  // received payload
  input wire logic rxDataValid, // payload byte strobe
  input wire logic [DATA_W-1:0] rxData, // payload byte
  input wire logic rxDataLast, // last payload byte
  // host output buffer
  output logic hostDataValid, // byte to host
  output logic [DATA_W-1:0] hostData, // byte value
  output logic hostDataLast, // last byte of packet
  // acknowledge and status
  output logic ackSend, // send acknowledge pulse
  output logic pktAccepted, // packet accepted pulse
  output logic pktDropped, // packet dropped pulse
  output logic pktWasGlobal, // last accepted was global
  output logic [2:0] dropReason, // failed checks of last drop
  output logic [CNT_W-1:0] acceptCount, // accepted packets
  output logic [CNT_W-1:0] dropCount, // dropped packets
  output logic rxBusy, // payload in progress
  // peer timing
  output logic syncLocked, // hop pattern held
  output logic masterRole, // module leads timing
  output logic txReady // transmit permitted
);

  rpf_rx_state_e state_reg;
  rpf_rx_state_e state_next;

  logic hopOk;
  logic tagOk;
  logic addrOk;
  logic maskedGlobal;
  logic maskedLocal;
  logic hdrPass;
  logic [ADDR_W-1:0] maskedDest;
  logic [ADDR_W-1:0] maskedSource;
  logic [2:0] failBits;
  logic hdrTaken;
  logic acceptNow;
  logic dropNow;
  logic ackWanted;
  logic byteTaken;
  logic byteForward;
  logic lastTaken;
  logic initHeard;

  // incoming destination under own mask
  always_comb begin
    maskedDest = rxDestinationAddress & addressMask;
  end

  // own address under the same mask
  always_comb begin
    maskedSource = sourceAddress & addressMask;
  end

  // channel layer
  always_comb begin
    hopOk = (rxHoppingChannel == hoppingChannel);
  end

  // network tag layer
  always_comb begin
    tagOk = (rxVendorNetworkTag == vendorNetworkTag);
  end

  // address layer: global or local match
  always_comb begin
    maskedGlobal = (maskedDest == addressMask);
  end

  always_comb begin
    maskedLocal = (maskedDest == maskedSource);
  end

  always_comb begin
    addrOk = maskedGlobal || maskedLocal;
  end

  // all three layers must pass
  always_comb begin
    hdrPass = hopOk && tagOk && addrOk;
  end

  // one bit for each failing layer
  always_comb begin
    failBits = 3'h0;
    failBits[RPF_REASON_HOP] = !hopOk;
    failBits[RPF_REASON_TAG] = !tagOk;
    failBits[RPF_REASON_ADDR] = !addrOk;
  end

  // a header is only taken between packets
  assign hdrTaken = rxHdrValid && (state_reg == RPF_IDLE);

  // verdict of the header taken this cycle
  assign acceptNow = hdrTaken && hdrPass;
  assign dropNow = hdrTaken && !hdrPass;

  // global packets never acknowledged
  assign ackWanted = acceptNow && rxAckRequested && !maskedGlobal;

  // bytes count only while a packet is open
  assign byteTaken = rxDataValid && (state_reg != RPF_IDLE);
  assign byteForward = rxDataValid && (state_reg == RPF_FORWARD);
  assign lastTaken = byteTaken && rxDataLast;

  // initializer counts only on our channel and network
  assign initHeard = rxHdrValid && rxInitializer && hopOk && tagOk;

  // a byte in the header cycle is ignored
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      RPF_IDLE: begin
        if (rxHdrValid) begin
          state_next = hdrPass ? RPF_FORWARD : RPF_DISCARD;
        end
      end
      RPF_FORWARD: begin
        if (lastTaken) begin
          state_next = RPF_IDLE;
        end
      end
      RPF_DISCARD: begin
        if (lastTaken) begin
          state_next = RPF_IDLE;
        end
      end
      default: begin
        state_next = RPF_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      state_reg <= RPF_IDLE;
    end else if (clkEn) begin
      state_reg <= state_next;
    end
  end

  assign rxBusy = (state_reg != RPF_IDLE);

  // payload path to host buffer
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      hostDataValid <= 1'b0;
    end else if (clkEn) begin
      hostDataValid <= byteForward;
    end
  end

  // byte value holds between bytes
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      hostData <= '0;
    end else if (clkEn && byteForward) begin
      hostData <= rxData;
    end
  end

  // last flag travels with its byte
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      hostDataLast <= 1'b0;
    end else if (clkEn) begin
      hostDataLast <= byteForward && rxDataLast;
    end
  end

  // verdict pulses
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      pktAccepted <= 1'b0;
    end else if (clkEn) begin
      pktAccepted <= acceptNow;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      pktDropped <= 1'b0;
    end else if (clkEn) begin
      pktDropped <= dropNow;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      ackSend <= 1'b0;
    end else if (clkEn) begin
      ackSend <= ackWanted;
    end
  end

  // status kept from the last verdict
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      pktWasGlobal <= 1'b0;
    end else if (clkEn && acceptNow) begin
      pktWasGlobal <= maskedGlobal;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      dropReason <= RPF_REASON_NONE;
    end else if (clkEn && dropNow) begin
      dropReason <= failBits;
    end
  end

  // counters wrap
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      acceptCount <= CNT_W'(RPF_CNT_RESET);
    end else if (clkEn && acceptNow) begin
      acceptCount <= acceptCount + CNT_W'(1);
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      dropCount <= CNT_W'(RPF_CNT_RESET);
    end else if (clkEn && dropNow) begin
      dropCount <= dropCount + CNT_W'(1);
    end
  end

  rpf_tx_classifier #(
    .ADDR_W(ADDR_W)
  ) u_tx_classifier (
    .clk_sys(clk_sys),
    .reset(reset),
    .clkEn(clkEn),
    .txStart(txStart),
    .transmitterDestination(transmitterDestination),
    .addressMask(addressMask),
    .txIsGlobal(txIsGlobal),
    .txIsLocal(txIsLocal),
    .txClassValid(txClassValid)
  );

  rpf_sync_timer #(
    .SYNC_CYCLES(SYNC_CYCLES),
    .COLD_START_CYCLES(COLD_START_CYCLES),
    .TIMER_W(RPF_TIMER_W)
  ) u_sync_timer (
    .clk_sys(clk_sys),
    .reset(reset),
    .clkEn(clkEn),
    .rxInitializer(initHeard),
    .syncLocked(syncLocked),
    .masterRole(masterRole),
    .txReady(txReady)
  );

endmodule // rpf_address_filter

/* tb/rpf_address_filter_asserts.sv */
// rpf_address_filter_asserts: port checks of the address filter.
// assumes one clock; checks pause while clkEn is low, except freeze_hold_a, which runs then.
`timescale 1ns/1ps
module rpf_address_filter_asserts import rpf_pkg::*; (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic clkEn,
  input wire logic txStart,
  input wire logic [15:0] transmitterDestination,
  input wire logic [15:0] addressMask,
  input wire logic [15:0] sourceAddress,
  input wire logic txClassValid,
  input wire logic txIsGlobal,
  input wire logic txIsLocal,
  input wire logic rxHdrValid,
  input wire logic rxBusy,
  input wire logic [15:0] rxDestinationAddress,
  input wire logic rxDataValid,
  input wire logic [7:0] rxData,
  input wire logic pktAccepted,
  input wire logic pktDropped,
  input wire logic ackSend,
  input wire logic [2:0] dropReason,
  input wire logic hostDataValid,
  input wire logic [7:0] hostData,
  input wire logic [15:0] acceptCount,
  input wire logic [15:0] dropCount
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset || !clkEn);
  logic take, glob, loc;
  logic [15:0] mDst;
  assign mDst = rxDestinationAddress & addressMask;
  assign take = rxHdrValid && !rxBusy;
  assign glob = mDst == addressMask;
  assign loc = mDst == (sourceAddress & addressMask);
  tx_class_a: assert property (txStart |=> txClassValid && txIsGlobal != txIsLocal)
    else $error("tx class missing");
  tx_global_a: assert property (
    txStart && transmitterDestination == RPF_GLOBAL_ADDR |=> txIsGlobal)
    else $error("all ones not global");
  tx_local_a: assert property (
    txStart && (transmitterDestination & addressMask) != addressMask |=> txIsLocal)
    else $error("tx not local");
  hdr_verdict_a: assert property (take |=> pktAccepted != pktDropped)
    else $error("no verdict");
  busy_refuse_a: assert property (rxHdrValid && rxBusy |=> !pktAccepted && !pktDropped)
    else $error("header taken while busy");
  addr_drop_a: assert property (
    take && !glob && !loc |=> pktDropped && dropReason[RPF_REASON_ADDR])
    else $error("address miss kept");
  glob_noack_a: assert property (take && glob |=> !ackSend)
    else $error("ack for global");
  ack_accept_a: assert property (ackSend |-> pktAccepted)
    else $error("ack without accept");
  host_fwd_a: assert property (
    hostDataValid |-> $past(rxDataValid) && hostData == $past(rxData))
    else $error("host byte wrong");
  freeze_hold_a: assert property (disable iff (reset)
    !clkEn |=> $stable(acceptCount) && $stable(dropCount) && $stable(txIsGlobal))
    else $error("state moved while frozen");
endmodule // rpf_address_filter_asserts
bind rpf_address_filter rpf_address_filter_asserts i_asserts (.*);

/* tb/rpf_peer_model.sv */
// rpf_peer_model: peer radio in range, sends headers and payload.
// assumes the filter samples on the rising edge of clk_sys.
`timescale 1ns/1ps
module rpf_peer_model (
  input wire logic clk_sys, // system clock
  output logic rxHdrValid, // header strobe
  output logic [6:0] rxHoppingChannel, // channel
  output logic [15:0] rxVendorNetworkTag, // tag
  output logic [15:0] rxDestinationAddress, // destination
  output logic rxAckRequested, // wants ack
  output logic rxInitializer, // hop initializer
  output logic rxDataValid, // byte strobe
  output logic [7:0] rxData, // byte
  output logic rxDataLast // last byte
);
  initial begin
    {rxHdrValid, rxAckRequested, rxInitializer, rxDataValid, rxDataLast} = '0;
    {rxHoppingChannel, rxVendorNetworkTag, rxDestinationAddress, rxData} = '0;
  end
  // released fields invert so stale values never pass
  task automatic sendHdr(input logic [6:0] ch, input logic [15:0] tag, dst,
                         input logic ack, ini);
    @(posedge clk_sys);
    #1;
    {rxHoppingChannel, rxVendorNetworkTag, rxDestinationAddress} = {ch, tag, dst};
    {rxAckRequested, rxInitializer, rxHdrValid} = {ack, ini, 1'b1};
    @(posedge clk_sys);
    #1;
    {rxHoppingChannel, rxVendorNetworkTag, rxDestinationAddress} = ~{ch, tag, dst};
    {rxAckRequested, rxInitializer, rxHdrValid} = 3'h0;
  endtask
  task automatic sendBytes(input logic [7:0] base, input int n);
    for (int i = 0; i < n; i++) begin
      {rxDataValid, rxDataLast, rxData} = {1'b1, i == n - 1, base + 8'(i)};
      @(posedge clk_sys);
      #1;
    end
    {rxDataValid, rxDataLast, rxData} = {2'h0, ~rxData};
  endtask
endmodule // rpf_peer_model

/* tb/test_rpf_address_filter.sv */
// test_rpf_address_filter: bench for the packet address filter.
// assumes the peer model frames headers and bytes on clk_sys.
`timescale 1ns/1ps
module test_rpf_address_filter import rpf_pkg::*;;
  typedef struct packed {
    logic [6:0] ch;
    logic [15:0] tag, dst;
    logic ack, acc, ackx, glb;
    logic [2:0] rsn;
  } rpf_row_s;
  localparam logic [15:0] MSK = 16'hFFF0;
  rpf_row_s r;
  rpf_row_s rows [8] = '{
    '{7'h05, 16'h3332, 16'h1234, 1'b1, 1'b1, 1'b1, 1'b0, 3'h0},
    '{7'h05, 16'h3332, 16'hFFFF, 1'b1, 1'b1, 1'b0, 1'b1, 3'h0},
    '{7'h05, 16'h3332, 16'hFFF3, 1'b1, 1'b1, 1'b0, 1'b1, 3'h0},
    '{7'h05, 16'h3332, 16'h123F, 1'b0, 1'b1, 1'b0, 1'b0, 3'h0},
    '{7'h05, 16'h3332, 16'h1244, 1'b1, 1'b0, 1'b0, 1'b0, 3'h4},
    '{7'h06, 16'h3332, 16'hFFFF, 1'b0, 1'b0, 1'b0, 1'b0, 3'h1},
    '{7'h05, 16'h3333, 16'hFFFF, 1'b0, 1'b0, 1'b0, 1'b0, 3'h2},
    '{7'h06, 16'h3333, 16'h1244, 1'b0, 1'b0, 1'b0, 1'b0, 3'h7}};
  // top bit: expected global class
  logic [16:0] txRows [4] = '{17'h1FFFF, 17'h01234, 17'h1FFF5, 17'h00000};
  logic clk_sys, reset, clkEn, txStart, txIsGlobal, txIsLocal, txClassValid;
  logic [6:0] hoppingChannel, rxHoppingChannel;
  logic [15:0] vendorNetworkTag, sourceAddress, addressMask, transmitterDestination;
  logic [15:0] rxVendorNetworkTag, rxDestinationAddress, acceptCount, dropCount;
  logic rxHdrValid, rxAckRequested, rxInitializer, rxDataValid, rxDataLast, rxBusy;
  logic [7:0] rxData, hostData;
  logic hostDataValid, hostDataLast, ackSend, pktAccepted, pktDropped, pktWasGlobal;
  logic [2:0] dropReason;
  logic syncLocked, masterRole, txReady;
  logic [8:0] hostQ [$];
  int nErrors = 0;
  int checks = 0;
  int cycles = 0;
  rpf_address_filter #(.SYNC_CYCLES(20), .COLD_START_CYCLES(30)) i_rpf_address_filter (.*);
  rpf_peer_model i_rpf_peer_model (.*);
  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    if (hostDataValid === 1'b1) hostQ.push_back({hostDataLast, hostData});
    cycles++;
    if (cycles == 3000) begin
      nErrors++;
      endSim();
    end
  end
  task automatic chkBit(input logic got, exp);
    checks++;
    if (got !== exp) begin
      nErrors++;
      $display("BAD t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic chkVal(input logic [15:0] got, exp);
    checks++;
    if (got !== exp) begin
      nErrors++;
      $display("BAD t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic endSim();
    $display("errors %0d checks %0d", nErrors, checks);
    if (nErrors == 0 && checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic waitCyc(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  task automatic doReset();
    reset = 1'b1;
    waitCyc(2);
    reset = 1'b0;
  endtask
  initial begin
    {clkEn, txStart, hoppingChannel, vendorNetworkTag} = {2'b10, 7'h05, 16'h3332};
    {sourceAddress, addressMask, transmitterDestination} = {16'h1230, MSK, 16'hFFFF};
    doReset();
    chkVal(acceptCount, 16'h0000);
    waitCyc(17);
    chkBit(syncLocked, 1'b0);
    waitCyc(6);
    chkBit(syncLocked, 1'b1);
    chkBit(masterRole, 1'b1);
    chkBit(txReady, 1'b0);
    waitCyc(10);
    chkBit(txReady, 1'b1);
    doReset();
    i_rpf_peer_model.sendHdr(7'h05, 16'h3332, 16'h1244, 1'b0, 1'b1);
    chkBit(syncLocked, 1'b1);
    chkBit(masterRole, 1'b0);
    i_rpf_peer_model.sendBytes(8'h11, 1);
    foreach (txRows[k]) begin
      {txStart, transmitterDestination} = {1'b1, txRows[k][15:0]};
      waitCyc(1);
      chkBit(txClassValid, 1'b1);
      chkBit(txIsGlobal, txRows[k][16]);
      chkBit(txIsLocal, !txRows[k][16]);
    end
    txStart = 1'b0;
    foreach (rows[i]) begin
      r = rows[i];
      i_rpf_peer_model.sendHdr(r.ch, r.tag, r.dst, r.ack, 1'b0);
      chkBit(pktAccepted, r.acc);
      chkBit(pktDropped, !r.acc);
      chkBit(ackSend, r.ackx);
      if (r.acc) chkBit(pktWasGlobal, r.glb);
      else chkVal(16'(dropReason), 16'(r.rsn));
      hostQ = {};
      i_rpf_peer_model.sendBytes(8'hA0 + 8'(i), 2);
      waitCyc(1);
      chkVal(16'(hostQ.size()), r.acc ? 16'h0002 : 16'h0000);
      if (r.acc) chkVal(16'(hostQ[1]), 16'h0100 | 16'(8'hA1 + 8'(i)));
    end
    i_rpf_peer_model.sendHdr(7'h05, 16'h3332, 16'hFFFF, 1'b0, 1'b0);
    chkBit(rxBusy, 1'b1);
    i_rpf_peer_model.sendHdr(7'h06, 16'h3332, 16'hFFFF, 1'b0, 1'b0);
    chkBit(pktDropped, 1'b0);
    hostQ = {};
    i_rpf_peer_model.sendBytes(8'h5A, 1);
    waitCyc(1);
    chkVal(16'(hostQ[0]), 16'h015A);
    chkVal(acceptCount, 16'h0005);
    chkVal(dropCount, 16'h0005);
    // frozen: header and classify request must leave no trace
    clkEn = 1'b0;
    {txStart, transmitterDestination} = {1'b1, 16'hFFFF};
    i_rpf_peer_model.sendHdr(7'h05, 16'h3332, 16'h1230, 1'b1, 1'b0);
    {clkEn, txStart} = 2'b10;
    chkBit(txClassValid, 1'b0);
    chkBit(txIsGlobal, 1'b0);
    chkBit(pktAccepted, 1'b0);
    chkVal(acceptCount, 16'h0005);
    waitCyc(1);
    chkBit(rxBusy, 1'b0);
    endSim();
  end
endmodule // test_rpf_address_filter
